//--- typec_alert_map.svh
// Purpose: Offsets, field positions, reset values and fixed codes of the alert bank.
// Assumes: 8-bit registers reached through the two-wire slave port.
// Notes: Definitions only.
`ifndef TYPEC_ALERT_MAP_SVH
`define TYPEC_ALERT_MAP_SVH

// --------------------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------------------
`define OFS_ALERT_SUMMARY 8'h0B
`define OFS_ALERT_MASK 8'h0C
`define OFS_CONNECTION_CHANGE 8'h0D
`define OFS_CONNECTION_STATE 8'h0E
`define OFS_VCONN_MONITOR_CONFIG 8'h20
`define OFS_VBUS_RANGE_CONFIG 8'h22
`define OFS_SOFT_RESET_CONTROL 8'h23
`define OFS_VBUS_DRAIN_TIME 8'h25
`define OFS_VBUS_DRAIN_STATE 8'h26
`define OFS_VBUS_PATH_STATE 8'h27
`define OFS_VBUS_MONITOR_CONFIG 8'h2E

// --------------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------------
`define BIT_LINK_CHANGE 6
`define BIT_SUPPLY_WATCH 5
`define BIT_FAULT_CHANGE 4
`define BIT_ATTACH_TOGGLED 0
`define BIT_SOFT_RESET 0

// --------------------------------------------------------------------------
// Reset values and fixed bits
// --------------------------------------------------------------------------
`define RST_ALERT_SUMMARY 8'h20
`define MASK_RESERVED_ONES 8'h8F
`define MASK_WRITABLE 8'h70
`define RST_CONNECTION_CHANGE 8'h00
`define RST_CONFIG 8'h00
`define RST_SOFT_RESET_CONTROL 8'h00

// --------------------------------------------------------------------------
// Two-wire slave address
// --------------------------------------------------------------------------
`define SLAVE_ADDR_BASE 7'h28
`define BITS_PER_BYTE 4'h8

`endif

//--- typec_alert_pkg.sv
// Purpose: Types shared by the alert and connection-status bank.
// Assumes: Constants live in typec_alert_map.svh.
// Notes: The whole module state is one packed struct.
package typec_alert_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WRITE,
    ST_WRITE_ACK,
    ST_READ,
    ST_READ_ACK
  } serial_state_t;

  typedef struct packed {
    logic [2:0] partner_kind;
    logic source_role_active;
    logic plug_power_on;
    logic partner_present;
  } link_status_t;

  typedef struct packed {
    logic [7:0] vconn_monitor_config;
    logic [7:0] vbus_range_config;
    logic [7:0] vbus_drain_time;
    logic [7:0] vbus_monitor_config;
  } supply_config_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic scl_q;
    logic sda_q;
    serial_state_t st;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic rw;
    logic sda_drive;
    logic loaded;
    logic standby;
    logic attach_prev;
    logic blocks_on;
    logic alert_n;
    logic [7:0] alert_summary;
    logic [7:0] alert_mask;
    logic [7:0] connection_change;
    logic [7:0] soft_reset_control;
    supply_config_t cfg;
  } bank_t;

endpackage : typec_alert_pkg

//--- typec_alert_status_regs.sv
// Purpose: Alert aggregation and connection-status register bank with two-wire slave port.
// Assumes: Pins scl and sda are asynchronous; all other inputs are on clk.
// Notes: Defaults marked as non-volatile are caught from nvm_* inputs after reset.
`timescale 1ns/1ps
`include "typec_alert_map.svh"

// Functional notes
// - Transition register change sets matching summary alert.
// - Summary bits 6,5,4; bit 5 resets one.
// - Read-clear registers clear after being read.
// - Mask bit set blocks summary bit assertion.
// - Mask bits 6:4 default from nvm_inhibit; others ones.
// - Alert low when summary AND not-mask nonzero.
// - Change bit 0 flags attach toggling.
// - Partner kind field in bits 7:5.
// - Bit 4 reports standby power mode.
// - Standby keeps front ends off until attach.
// - Standby only when non-volatile setting enables.
// - Bit 3 shows source role when attached; here it shows source_role_active whether attached or not.
// - Bit 1 shows plug power; bit 2 reserved.
// - Bit 0 shows partner present.
// - Defaults load at reset, some non-volatile.
// - Register 23h commands device reset.
// - Writable supply controls at 22h, 25h, 2Eh.
// - Register 20h writable; listed gaps read-only.
module typec_alert_status_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_sel,
  input wire typec_alert_pkg::link_status_t link,
  input wire logic supply_watch_event,
  input wire logic fault_change_event,
  input wire logic [7:0] vbus_drain_state,
  input wire logic [7:0] vbus_path_state,
  input wire logic [2:0] nvm_inhibit,
  input wire logic nvm_standby,
  output logic alert_n,
  output typec_alert_pkg::supply_config_t supply_config,
  output logic soft_reset,
  output logic front_end_on
);
  import typec_alert_pkg::*;

  // --------------------------------------------------------------------------
  // Reset state
  // --------------------------------------------------------------------------
  localparam bank_t BANK_RESET = '{
    scl_s1: 1'b1,
    scl_s2: 1'b1,
    sda_s1: 1'b1,
    sda_s2: 1'b1,
    scl_q: 1'b1,
    sda_q: 1'b1,
    st: ST_IDLE,
    cnt: 4'h0,
    shift: 8'h00,
    tx: 8'h00,
    ptr: 8'h00,
    rw: 1'b0,
    sda_drive: 1'b0,
    loaded: 1'b0,
    standby: 1'b0,
    attach_prev: 1'b0,
    blocks_on: 1'b0,
    alert_n: 1'b1,
    alert_summary: `RST_ALERT_SUMMARY,
    alert_mask: `MASK_RESERVED_ONES | `MASK_WRITABLE,
    connection_change: `RST_CONNECTION_CHANGE,
    soft_reset_control: `RST_SOFT_RESET_CONTROL,
    cfg: '{`RST_CONFIG, `RST_CONFIG, `RST_CONFIG, `RST_CONFIG}
  };

  bank_t q;
  bank_t n;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [7:0] rd_value;
    logic rd_take;
    logic wr_en;
    logic [7:0] wr_data;
    logic [7:0] wr_addr;
    logic attach_change;
    logic [7:0] alert_set;
    logic [7:0] change_set;
    logic reload;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_seen = 1'b0;
    stop_seen = 1'b0;
    rd_value = 8'h00;
    rd_take = 1'b0;
    wr_en = 1'b0;
    wr_data = 8'h00;
    wr_addr = 8'h00;
    attach_change = 1'b0;
    alert_set = 8'h00;
    change_set = 8'h00;
    reload = 1'b0;
    n = q;

    // Two-flop synchronisers; edge detection compares the second stage with its copy one cycle later (scl_q, sda_q).
    n.scl_s1 = scl;
    n.scl_s2 = q.scl_s1;
    n.sda_s1 = sda_in;
    n.sda_s2 = q.sda_s1;
    n.scl_q = q.scl_s2;
    n.sda_q = q.sda_s2;
    scl_rise = q.scl_s2 & ~q.scl_q;
    scl_fall = ~q.scl_s2 & q.scl_q;
    start_seen = q.scl_s2 & q.scl_q & q.sda_q & ~q.sda_s2;
    stop_seen = q.scl_s2 & q.scl_q & ~q.sda_q & q.sda_s2;

    // Register read view at the current pointer; unmapped and reserved read zero.
    unique case (q.ptr)
      `OFS_ALERT_SUMMARY: begin
        rd_value = q.alert_summary;
      end
      `OFS_ALERT_MASK: begin
        rd_value = q.alert_mask;
      end
      `OFS_CONNECTION_CHANGE: begin
        rd_value = q.connection_change;
      end
      `OFS_CONNECTION_STATE: rd_value = {link.partner_kind, q.standby,
          link.source_role_active, 1'b0, link.plug_power_on,
          link.partner_present};
      `OFS_VCONN_MONITOR_CONFIG: begin
        rd_value = q.cfg.vconn_monitor_config;
      end
      `OFS_VBUS_RANGE_CONFIG: begin
        rd_value = q.cfg.vbus_range_config;
      end
      `OFS_SOFT_RESET_CONTROL: begin
        rd_value = q.soft_reset_control;
      end
      `OFS_VBUS_DRAIN_TIME: begin
        rd_value = q.cfg.vbus_drain_time;
      end
      `OFS_VBUS_DRAIN_STATE: begin
        rd_value = vbus_drain_state;
      end
      `OFS_VBUS_PATH_STATE: begin
        rd_value = vbus_path_state;
      end
      `OFS_VBUS_MONITOR_CONFIG: begin
        rd_value = q.cfg.vbus_monitor_config;
      end
      default: begin
        rd_value = 8'h00;
      end
    endcase

    // ------------------------------------------------------------------------
    // Two-wire slave
    // ------------------------------------------------------------------------
    if (scl_rise) begin
      n.shift = {q.shift[6:0], q.sda_s2};
      n.cnt = q.cnt + 4'h1;
    end
    if (start_seen) begin
      n.st = ST_ADDR;
      n.cnt = 4'h0;
      n.sda_drive = 1'b0;
    end else if (stop_seen) begin
      n.st = ST_IDLE;
      n.sda_drive = 1'b0;
    end else if (scl_fall) begin
      unique case (q.st)
        ST_IDLE: begin
          n.sda_drive = 1'b0;
        end
        ST_ADDR: begin
          if (q.cnt == `BITS_PER_BYTE) begin
            if (q.shift[7:1] == {`SLAVE_ADDR_BASE | {6'h00, addr_sel}}) begin
              n.st = ST_ADDR_ACK;
              n.rw = q.shift[0];
              n.sda_drive = 1'b1;
            end else begin
              n.st = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          n.cnt = 4'h0;
          if (q.rw) begin
            rd_take = 1'b1;
            n.st = ST_READ;
            n.tx = {rd_value[6:0], 1'b0};
            n.sda_drive = ~rd_value[7];
            n.ptr = q.ptr + 8'h01;
          end else begin
            n.st = ST_PTR;
            n.sda_drive = 1'b0;
          end
        end
        ST_PTR: begin
          if (q.cnt == `BITS_PER_BYTE) begin
            n.ptr = q.shift;
            n.st = ST_PTR_ACK;
            n.sda_drive = 1'b1;
          end
        end
        ST_PTR_ACK, ST_WRITE_ACK: begin
          n.cnt = 4'h0;
          n.st = ST_WRITE;
          n.sda_drive = 1'b0;
        end
        ST_WRITE: begin
          if (q.cnt == `BITS_PER_BYTE) begin
            wr_en = 1'b1;
            wr_addr = q.ptr;
            wr_data = q.shift;
            n.ptr = q.ptr + 8'h01;
            n.st = ST_WRITE_ACK;
            n.sda_drive = 1'b1;
          end
        end
        ST_READ: begin
          if (q.cnt == `BITS_PER_BYTE) begin
            n.st = ST_READ_ACK;
            n.sda_drive = 1'b0;
            n.cnt = 4'h0;
          end else begin
            n.sda_drive = ~q.tx[7];
            n.tx = {q.tx[6:0], 1'b0};
          end
        end
        ST_READ_ACK: begin
          n.cnt = 4'h0;
          if (q.shift[0]) begin
            n.st = ST_IDLE;
            n.sda_drive = 1'b0;
          end else begin
            rd_take = 1'b1;
            n.st = ST_READ;
            n.tx = {rd_value[6:0], 1'b0};
            n.sda_drive = ~rd_value[7];
            n.ptr = q.ptr + 8'h01;
          end
        end
      endcase
    end

    // ------------------------------------------------------------------------
    // Event capture
    // ------------------------------------------------------------------------
    attach_change = q.loaded & (link.partner_present != q.attach_prev);
    n.attach_prev = link.partner_present;
    change_set[`BIT_ATTACH_TOGGLED] = attach_change;
    alert_set[`BIT_LINK_CHANGE] = attach_change;
    alert_set[`BIT_SUPPLY_WATCH] = q.loaded & supply_watch_event;
    alert_set[`BIT_FAULT_CHANGE] = q.loaded & fault_change_event;
    alert_set = alert_set & ~q.alert_mask & `MASK_WRITABLE;

    // A read clears the register, but an event in the same cycle survives.
    if (rd_take && q.ptr == `OFS_ALERT_SUMMARY) begin
      n.alert_summary = alert_set;
    end else begin
      n.alert_summary = q.alert_summary | alert_set;
    end
    if (rd_take && q.ptr == `OFS_CONNECTION_CHANGE) begin
      n.connection_change = change_set;
    end else begin
      n.connection_change = q.connection_change | change_set;
    end

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    if (wr_en) begin
      unique case (wr_addr)
        `OFS_ALERT_MASK: begin
          n.alert_mask = (wr_data & `MASK_WRITABLE) | `MASK_RESERVED_ONES;
        end
        `OFS_VCONN_MONITOR_CONFIG: begin
          n.cfg.vconn_monitor_config = wr_data;
        end
        `OFS_VBUS_RANGE_CONFIG: begin
          n.cfg.vbus_range_config = wr_data;
        end
        `OFS_SOFT_RESET_CONTROL: begin
          n.soft_reset_control = wr_data;
        end
        `OFS_VBUS_DRAIN_TIME: begin
          n.cfg.vbus_drain_time = wr_data;
        end
        `OFS_VBUS_MONITOR_CONFIG: begin
          n.cfg.vbus_monitor_config = wr_data;
        end
        default: begin
        end
      endcase
    end

    // ------------------------------------------------------------------------
    // Default loading after reset and while software reset is held
    // ------------------------------------------------------------------------
    reload = ~q.loaded | q.soft_reset_control[`BIT_SOFT_RESET];
    if (reload) begin
      n.loaded = 1'b1;
      n.alert_summary = `RST_ALERT_SUMMARY;
      n.alert_mask = {1'b1, nvm_inhibit, 4'hF} | `MASK_RESERVED_ONES;
      n.connection_change = `RST_CONNECTION_CHANGE;
      n.standby = nvm_standby;
      n.attach_prev = link.partner_present;
      n.cfg = '{`RST_CONFIG, `RST_CONFIG, `RST_CONFIG, `RST_CONFIG};
    end

    // Standby keeps the CC and monitoring front ends down until attach.
    n.blocks_on = n.loaded & (~n.standby | link.partner_present);
    n.alert_n = ~|(n.alert_summary & ~n.alert_mask);
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= BANK_RESET;
    end else begin
      q <= n;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign sda_out = 1'b0;
  assign sda_oe = q.sda_drive;
  assign alert_n = q.alert_n;
  assign supply_config = q.cfg;
  assign soft_reset = q.soft_reset_control[`BIT_SOFT_RESET];
  assign front_end_on = q.blocks_on;

endmodule : typec_alert_status_regs

//--- typec_alert_status_regs_checker.sv
// Purpose: Port-level assertions for the alert and connection-status bank.
// Assumes: Bound to typec_alert_status_regs; mask and summary are not visible here.
// Notes: Checks tie outputs to bus phases, event pulses and the attach input.
`timescale 1ns/1ps
module typec_alert_status_regs_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_oe,
  input wire typec_alert_pkg::link_status_t link,
  input wire logic supply_watch_event,
  input wire logic fault_change_event,
  input wire logic nvm_standby,
  input wire logic alert_n,
  input wire typec_alert_pkg::supply_config_t supply_config,
  input wire logic soft_reset,
  input wire logic front_end_on
);
  import typec_alert_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_attach_front;
    !$past(rst, 2) && $past(link.partner_present) |-> front_end_on;
  endproperty
  a_attach_front: assert property (p_attach_front) else $error("front end off");
  property p_standby_off;
    !$past(rst, 2) && !$past(soft_reset) && !$past(soft_reset, 2) && nvm_standby
      && !$past(link.partner_present) |-> !front_end_on;
  endproperty
  a_standby_off: assert property (p_standby_off) else $error("front end on");
  property p_alert_release;
    $rose(alert_n) |-> !scl;
  endproperty
  a_alert_release: assert property (p_alert_release) else $error("alert released");
  property p_alert_cause;
    $fell(alert_n) |-> !scl || $past(rst, 2) || $past(supply_watch_event)
      || $past(fault_change_event) || $past(link.partner_present) != $past(link.partner_present, 4);
  endproperty
  a_alert_cause: assert property (p_alert_cause) else $error("alert with no cause");
  property p_soft_rose;
    $rose(soft_reset) |-> !scl;
  endproperty
  a_soft_rose: assert property (p_soft_rose) else $error("soft reset not from bus");
  property p_soft_reload;
    soft_reset |=> supply_config == '0;
  endproperty
  a_soft_reload: assert property (p_soft_reload) else $error("config kept");
  property p_config_bus;
    !$stable(supply_config) |-> !scl;
  endproperty
  a_config_bus: assert property (p_config_bus) else $error("config moved");
  property p_sda_turn;
    !$stable(sda_oe) |-> !scl;
  endproperty
  a_sda_turn: assert property (p_sda_turn) else $error("data moved with clock high");
endmodule : typec_alert_status_regs_checker

bind typec_alert_status_regs typec_alert_status_regs_checker u_typec_alert_status_regs_checker (
  .clk(clk), .rst(rst), .scl(scl), .sda_oe(sda_oe), .link(link),
  .supply_watch_event(supply_watch_event), .fault_change_event(fault_change_event),
  .nvm_standby(nvm_standby), .alert_n(alert_n), .supply_config(supply_config),
  .soft_reset(soft_reset), .front_end_on(front_end_on)
);

//--- i2c_host_model.sv
// Purpose: Two-wire bus host that reaches the bank registers.
// Assumes: Open-drain data line with a pull-up; target address 28h.
// Notes: Each of the three phases of a bus bit lasts QTR clock cycles.
`timescale 1ns/1ps
module i2c_host_model #(
  parameter int QTR = 10
) (
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda_line
);
  logic sda_h = 1'b1;
  int misses = 0;
  initial scl = 1'b1;
  // A released line floats to the pull-up level.
  assign sda_line = sda_h & ~sda_oe;
  task automatic tick;
    repeat (QTR) @(posedge clk);
    #1;
  endtask : tick
  task automatic bit_io(input logic b, output logic r);
    tick();
    sda_h = b;
    tick();
    scl = 1'b1;
    tick();
    r = sda_line;
    scl = 1'b0;
  endtask : bit_io
  task automatic start;
    tick();
    sda_h = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_h = 1'b0;
    tick();
    scl = 1'b0;
  endtask : start
  task automatic stop;
    tick();
    sda_h = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_h = 1'b1;
    tick();
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic rd, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(1'b1, a);
    if (!rd && a !== 1'b0) begin
      misses++;
    end
  endtask : xfer
  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] q;
    start();
    xfer(8'h50, 1'b0, q);
    xfer(ofs, 1'b0, q);
    xfer(d, 1'b0, q);
    stop();
  endtask : write_reg
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
    logic [7:0] q;
    start();
    xfer(8'h50, 1'b0, q);
    xfer(ofs, 1'b0, q);
    start();
    xfer(8'h51, 1'b0, q);
    xfer(8'hFF, 1'b1, d);
    stop();
  endtask : read_reg
endmodule : i2c_host_model

//--- typec_alert_status_regs_tb_top.sv
// Purpose: Self-checking bench for the alert and connection-status bank.
// Assumes: The host model drives the bus; other inputs change 1 ns after clk rises.
// Notes: Register rows run first, then alert, soft reset and reset cases.
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module typec_alert_status_regs_tb_top;
  import typec_alert_pkg::*;
  typedef struct packed {
    logic [2:0] kind;
    logic [7:0] ofs;
    logic [7:0] wdata;
    logic [7:0] want;
  } row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl;
  logic sda_in;
  logic sda_oe;
  logic addr_sel = 1'b0;
  link_status_t link = '0;
  logic supply_watch_event = 1'b0;
  logic fault_change_event = 1'b0;
  logic nvm_standby = 1'b1;
  logic alert_n;
  supply_config_t supply_config;
  logic soft_reset;
  logic front_end_on;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  row_t rows [15] = '{'{3'd0, 8'h20, 8'hA5, 8'hA5}, '{3'd0, 8'h22, 8'h5A, 8'h5A},
    '{3'd0, 8'h25, 8'h3C, 8'h3C}, '{3'd0, 8'h2E, 8'hC3, 8'hC3}, '{3'd0, 8'h21, 8'hFF, 8'h00},
    '{3'd0, 8'h24, 8'hFF, 8'h00}, '{3'd0, 8'h2D, 8'hFF, 8'h00}, '{3'd0, 8'h2F, 8'hFF, 8'h00},
    '{3'd0, 8'h05, 8'hFF, 8'h00}, '{3'd0, 8'h26, 8'h00, 8'h96}, '{3'd0, 8'h27, 8'h00, 8'h69},
    '{3'd1, 8'h0E, 8'hFF, 8'h30}, '{3'd3, 8'h0E, 8'hFF, 8'h70}, '{3'd4, 8'h0E, 8'hFF, 8'h90},
    '{3'd0, 8'h0E, 8'hFF, 8'h10}};
  typec_alert_status_regs u_typec_alert_status_regs (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe),
    .addr_sel(addr_sel), .link(link), .supply_watch_event(supply_watch_event),
    .fault_change_event(fault_change_event), .vbus_drain_state(8'h96),
    .vbus_path_state(8'h69), .nvm_inhibit(3'b101), .nvm_standby(nvm_standby), .alert_n(alert_n),
    .supply_config(supply_config), .soft_reset(soft_reset), .front_end_on(front_end_on)
  );
  i2c_host_model u_i2c_host_model (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda_line(sda_in));
  task automatic give_verdict;
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  task automatic rd(input logic [7:0] ofs, input logic [7:0] want);
    logic [7:0] got;
    u_i2c_host_model.read_reg(ofs, got);
    `CHK(got, want)
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    settle(20);
    rst = 1'b0;
    settle(4);
    foreach (rows[i]) begin
      link.partner_kind = rows[i].kind;
      u_i2c_host_model.write_reg(rows[i].ofs, rows[i].wdata);
      rd(rows[i].ofs, rows[i].want);
    end
    `CHK(supply_config, 32'hA55A3CC3)
    `CHK(alert_n, 1'b0)
    `CHK(front_end_on, 1'b0)
    rd(8'h0B, 8'h20);
    rd(8'h0B, 8'h00);
    `CHK(alert_n, 1'b1)
    rd(8'h0C, 8'hDF);
    link = '{3'b001, 1'b1, 1'b1, 1'b1};
    settle(3);
    `CHK(front_end_on, 1'b1)
    rd(8'h0E, 8'h3B);
    rd(8'h0D, 8'h01);
    rd(8'h0D, 8'h00);
    rd(8'h0B, 8'h00);
    u_i2c_host_model.write_reg(8'h0C, 8'h00);
    rd(8'h0C, 8'h8F);
    link.partner_present = 1'b0;
    settle(4);
    `CHK(alert_n, 1'b0)
    rd(8'h0B, 8'h40);
    rd(8'h0D, 8'h01);
    `CHK(alert_n, 1'b1)
    for (int i = 0; i < 2; i++) begin
      {supply_watch_event, fault_change_event} = i ? 2'b01 : 2'b10;
      settle(1);
      {supply_watch_event, fault_change_event} = 2'b00;
      settle(3);
      `CHK(alert_n, 1'b0)
      rd(8'h0B, i ? 8'h10 : 8'h20);
    end
    addr_sel = 1'b1;
    u_i2c_host_model.write_reg(8'h20, 8'h00);
    `CHK(u_i2c_host_model.misses, 3)
    addr_sel = 1'b0;
    rd(8'h20, 8'hA5);
    u_i2c_host_model.write_reg(8'h23, 8'h01);
    `CHK(soft_reset, 1'b1)
    rd(8'h23, 8'h01);
    u_i2c_host_model.write_reg(8'h23, 8'h00);
    `CHK(soft_reset, 1'b0)
    `CHK(supply_config, 32'h0)
    rd(8'h0C, 8'hDF);
    rd(8'h0B, 8'h20);
    nvm_standby = 1'b0;
    rst = 1'b1;
    settle(2);
    rst = 1'b0;
    settle(4);
    `CHK(front_end_on, 1'b1)
    `CHK(alert_n, 1'b0)
    rd(8'h0E, 8'h2A);
    give_verdict();
  end
endmodule : typec_alert_status_regs_tb_top
